/* rtl/rcrf_pkg.sv */
// ============================================================
// Shared constants and types for the remote configuration request framer.
package rcrf_pkg;

	// ============================================================
	// Frame bytes and positions.
	localparam logic [7:0] RCRF_START_MARK = 8'h7e;
	localparam logic [7:0] RCRF_TYPE_REMOTE_CFG = 8'h17;
	localparam logic [7:0] RCRF_CSUM_GOOD = 8'hff;
	localparam logic [15:0] RCRF_POS_TYPE = 16'h0003;
	localparam logic [15:0] RCRF_POS_ID = 16'h0004;
	localparam logic [15:0] RCRF_POS_DEST64 = 16'h0005;
	localparam logic [15:0] RCRF_POS_DEST16 = 16'h000d;
	localparam logic [15:0] RCRF_POS_OPT = 16'h000f;
	localparam logic [15:0] RCRF_POS_CMD = 16'h0010;
	localparam logic [15:0] RCRF_POS_VALUE = 16'h0012;
	// Bytes from the type code through the second command character.
	localparam logic [15:0] RCRF_HDR_LEN = 16'h000f;

	// ============================================================
	// Option bits and special field values.
	localparam int RCRF_OPT_NO_ACK = 0;
	localparam int RCRF_OPT_APPLY = 1;
	localparam int RCRF_OPT_RSVD_LO = 2;
	localparam int RCRF_OPT_RSVD_HI = 3;
	localparam int RCRF_OPT_SECURE = 4;
	localparam logic [15:0] RCRF_CMD_APPLY_PENDING = 16'h4143;
	localparam logic [63:0] RCRF_DEST64_USE_SHORT = 64'hffff_ffff_ffff_ffff;
	localparam logic [15:0] RCRF_DEST16_UNKNOWN = 16'hfffe;
	localparam logic [7:0] RCRF_ID_NO_RESPONSE = 8'h00;

	// ============================================================
	// Register map, byte addresses.
	localparam logic [7:0] RCRF_REG_CTRL = 8'h00;
	localparam logic [7:0] RCRF_REG_STATUS = 8'h04;
	localparam logic [7:0] RCRF_REG_GOOD_CNT = 8'h08;
	localparam logic [7:0] RCRF_REG_CSUM_ERR_CNT = 8'h0c;
	localparam logic [7:0] RCRF_REG_LEN_ERR_CNT = 8'h10;
	localparam logic [7:0] RCRF_REG_LAST = 8'h14;
	localparam int RCRF_CTRL_ENABLE = 0;
	localparam int RCRF_CTRL_APPLY = 1;
	localparam int RCRF_ST_PENDING = 0;
	localparam int RCRF_ST_IN_FRAME = 1;
	localparam int RCRF_ST_RSVD_SEEN = 2;
	localparam int RCRF_ST_SECURE_REFUSED = 3;
	localparam logic RCRF_CTRL_ENABLE_RST = 1'b1;

	// ============================================================
	// Types.
	typedef enum logic [2:0] {
		RCRF_IDLE = 3'b000,
		RCRF_LEN_HI = 3'b001,
		RCRF_LEN_LO = 3'b010,
		RCRF_BODY = 3'b011,
		RCRF_CSUM = 3'b100
	} rcrf_state_e;

	typedef struct packed {
		logic [7:0] frame_id;
		logic [63:0] dest64;
		logic [15:0] dest16;
		logic [7:0] options;
		logic [15:0] command;
		logic [15:0] value_len;
	} rcrf_req_s;

endpackage

/* rtl/rcrf_value_store.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Byte store for the parameter value of the latest request.
module rcrf_value_store #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem [DEPTH];

	// The array itself has no reset; only the read register does.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read, one cycle after the address.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

/* rtl/rcrf_framer.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - Frame starts at start marker byte.
// R2 - Length counts bytes between length and checksum.
// R3 - Type byte selects remote configuration request.
// R4 - Zero identifier suppresses the response.
// R5 - Sender puts all ones when short-addressing.
// R6 - Sender puts unknown marker in short address.
// R7 - Option bit zero disables acknowledgment.
// R8 - Bit one applies now, else change pends.
// R9 - Sender keeps option bits two, three zero.
// R10 - Bit four secure only with session.
// R11 - Two ASCII characters name the command.
// R12 - No value bytes means a read.
// R13 - Checksum is 0xFF minus low sum byte.
// R14 - Response repeats the request identifier.
// R15 - Bad checksum or length discarded, resync.
module rcrf_framer
	import rcrf_pkg::*;
#(
	parameter int MAX_VAL = 64
) (
	input wire logic CLOCK,
	input wire logic RST_B,
	// Byte stream from the host, same clock domain.
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	// Secure session state from the session logic.
	input wire logic SECURE_SESSION_UP,
	// Parsed request.
	output rcrf_pkg::rcrf_req_s REQ,
	output logic REQ_VALID,
	output logic REQ_IS_READ,
	output logic REQ_NO_ACK,
	output logic REQ_SECURE,
	// Response trigger and the identifier to echo.
	output logic RSP_REQ,
	output logic [7:0] RSP_FRAME_ID,
	// Change control and frame error.
	output logic APPLY_NOW,
	output logic CHANGE_PENDING,
	output logic FRAME_ERROR,
	// Value byte read port.
	input wire logic [$clog2(MAX_VAL)-1:0] VAL_IDX,
	output logic [7:0] VAL_DATA,
	// Register port.
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic WR_STB,
	input wire logic RD_STB,
	output logic [31:0] RD_DATA
);

	import rcrf_pkg::*;

	localparam int VAW = $clog2(MAX_VAL);
	localparam logic [15:0] MAX_VAL_W = 16'(MAX_VAL);

	// ============================================================
	// Declarations.
	rcrf_state_e state_reg;
	rcrf_state_e state_next;
	logic [15:0] len_reg;
	logic [15:0] cnt_reg;
	logic [7:0] sum_reg;
	logic [7:0] type_reg;
	rcrf_req_s cap_reg;
	rcrf_req_s req_reg;
	logic req_valid_reg;
	logic rsp_req_reg;
	logic apply_reg;
	logic pending_reg;
	logic err_reg;
	logic csum_err_pulse;
	logic len_err_pulse;
	logic good_pulse;
	logic enable_reg;
	logic rsvd_seen_reg;
	logic sec_ref_reg;
	logic [15:0] good_cnt_reg;
	logic [15:0] csum_err_cnt_reg;
	logic [15:0] len_err_cnt_reg;
	logic [31:0] rd_data_reg;
	logic take;
	logic [15:0] pos;
	logic [15:0] vlen;
	logic csum_ok;
	logic len_ok;
	logic is_ours;
	logic sec_refused;
	logic sw_apply;
	logic cmd_apply;
	logic apply_evt;
	logic queue_evt;
	logic val_wr;

	// Adds a byte into the running one-byte sum.
	function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
		add8 = 8'(a + b);
	endfunction

	// Tells whether a write strobe hits a given register.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction

	// ============================================================
	// Byte acceptance and frame position.
	assign take = RX_VALID && enable_reg;
	assign pos = 16'(cnt_reg + RCRF_POS_TYPE);
	assign vlen = 16'(len_reg - RCRF_HDR_LEN);

	// End-of-frame checks, valid while the checksum byte is taken.
	assign csum_ok = (add8(sum_reg, RX_DATA) == RCRF_CSUM_GOOD); // R13
	assign len_ok = (len_reg >= RCRF_HDR_LEN) && (vlen <= MAX_VAL_W); // R2
	assign is_ours = (type_reg == RCRF_TYPE_REMOTE_CFG); // R3
	// A secure request without a session is not forwarded.
	assign sec_refused = cap_reg.options[RCRF_OPT_SECURE] && !SECURE_SESSION_UP; // R10

	assign csum_err_pulse = take && (state_reg == RCRF_CSUM) && !csum_ok; // R15
	assign len_err_pulse = take && (state_reg == RCRF_CSUM) && csum_ok && is_ours && !len_ok; // R15
	assign good_pulse = take && (state_reg == RCRF_CSUM) && csum_ok && is_ours && len_ok && !sec_refused;

	// ============================================================
	// Frame state machine.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			RCRF_IDLE: begin
				if (take && RX_DATA == RCRF_START_MARK) begin // R1
					state_next = RCRF_LEN_HI;
				end
			end
			RCRF_LEN_HI: begin
				if (take) begin
					state_next = RCRF_LEN_LO;
				end
			end
			RCRF_LEN_LO: begin
				if (take) begin
					state_next = ({len_reg[7:0], RX_DATA} == 16'h0000) ? RCRF_CSUM : RCRF_BODY; // R2
				end
			end
			RCRF_BODY: begin
				if (take && cnt_reg == 16'(len_reg - 16'h0001)) begin // R2
					state_next = RCRF_CSUM;
				end
			end
			RCRF_CSUM: begin
				// Any outcome returns to hunting for the next start marker.
				if (take) begin
					state_next = RCRF_IDLE; // R15
				end
			end
			default: begin
				state_next = RCRF_IDLE;
			end
		endcase
	end

	// State register; disabling the parser abandons a frame in progress.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= RCRF_IDLE;
		end else if (!enable_reg) begin
			state_reg <= RCRF_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Length field, high byte first, then low byte.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			len_reg <= 16'h0000;
		end else if (take && state_reg == RCRF_LEN_HI) begin
			len_reg <= {8'h00, RX_DATA};
		end else if (take && state_reg == RCRF_LEN_LO) begin
			len_reg <= {len_reg[7:0], RX_DATA}; // R2
		end
	end

	// Body byte counter and running checksum sum from the type byte on.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			cnt_reg <= 16'h0000;
			sum_reg <= 8'h00;
		end else if (take && state_reg == RCRF_LEN_LO) begin
			cnt_reg <= 16'h0000;
			sum_reg <= 8'h00;
		end else if (take && state_reg == RCRF_BODY) begin
			cnt_reg <= 16'(cnt_reg + 16'h0001);
			sum_reg <= add8(sum_reg, RX_DATA); // R13
		end
	end

	// Field capture by byte position within the frame.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			type_reg <= 8'h00;
			cap_reg <= '0;
		end else if (take && state_reg == RCRF_LEN_LO) begin
			type_reg <= 8'h00;
			cap_reg <= '0;
		end else if (take && state_reg == RCRF_BODY) begin
			if (pos == RCRF_POS_TYPE) begin
				type_reg <= RX_DATA; // R3
			end else if (pos == RCRF_POS_ID) begin
				cap_reg.frame_id <= RX_DATA; // R4
			end else if (pos >= RCRF_POS_DEST64 && pos < RCRF_POS_DEST16) begin
				// Destination fields are passed on as sent, most significant byte first.
				cap_reg.dest64 <= {cap_reg.dest64[55:0], RX_DATA}; // R5
			end else if (pos >= RCRF_POS_DEST16 && pos < RCRF_POS_OPT) begin
				cap_reg.dest16 <= {cap_reg.dest16[7:0], RX_DATA}; // R6
			end else if (pos == RCRF_POS_OPT) begin
				cap_reg.options <= RX_DATA; // R7
			end else if (pos >= RCRF_POS_CMD && pos < RCRF_POS_VALUE) begin
				cap_reg.command <= {cap_reg.command[7:0], RX_DATA}; // R11
			end
		end
	end

	// ============================================================
	// Value bytes go straight into the store as they arrive.
	assign val_wr = take && state_reg == RCRF_BODY && pos >= RCRF_POS_VALUE &&
		16'(pos - RCRF_POS_VALUE) < MAX_VAL_W; // R12

	// The store is rewritten by the next frame, so read values before it arrives.
	rcrf_value_store #(
		.DEPTH(MAX_VAL),
		.AW(VAW)
	) u_store (
		.clk(CLOCK),
		.rst_b(RST_B),
		.wr_en(val_wr),
		.wr_addr(VAW'(pos - RCRF_POS_VALUE)),
		.wr_data(RX_DATA),
		.rd_addr(VAL_IDX),
		.rd_data(VAL_DATA)
	);

	// ============================================================
	// Request output, updated only by a frame that passes every check.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			req_reg <= '0;
		end else if (good_pulse) begin
			req_reg <= cap_reg;
			req_reg.value_len <= vlen; // R12
		end
	end

	// One-cycle pulses for request, response and error.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			req_valid_reg <= 1'b0;
			rsp_req_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			req_valid_reg <= good_pulse;
			rsp_req_reg <= good_pulse && (cap_reg.frame_id != RCRF_ID_NO_RESPONSE); // R4
			err_reg <= csum_err_pulse || len_err_pulse; // R15
		end
	end

	assign REQ = req_reg;
	assign REQ_VALID = req_valid_reg;
	assign REQ_IS_READ = (req_reg.value_len == 16'h0000); // R12
	assign REQ_NO_ACK = req_reg.options[RCRF_OPT_NO_ACK]; // R7
	assign REQ_SECURE = req_reg.options[RCRF_OPT_SECURE]; // R10
	assign RSP_REQ = rsp_req_reg;
	assign RSP_FRAME_ID = req_reg.frame_id; // R14
	assign FRAME_ERROR = err_reg;

	// ============================================================
	// Change control: apply at once, or hold until an apply arrives.
	assign sw_apply = WR_STB && hit(ADDR, RCRF_REG_CTRL) && WR_DATA[RCRF_CTRL_APPLY];
	assign cmd_apply = good_pulse && (cap_reg.command == RCRF_CMD_APPLY_PENDING); // R8
	assign apply_evt = sw_apply || cmd_apply || (good_pulse && cap_reg.options[RCRF_OPT_APPLY]); // R8
	assign queue_evt = good_pulse && !cap_reg.options[RCRF_OPT_APPLY] && !cmd_apply && (vlen != 16'h0000); // R8

	// Apply pulse lines up with the request pulse.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			apply_reg <= 1'b0;
		end else begin
			apply_reg <= apply_evt;
		end
	end

	// A newly queued write wins over an apply in the same cycle.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pending_reg <= 1'b0;
		end else if (queue_evt) begin
			pending_reg <= 1'b1; // R8
		end else if (apply_evt) begin
			pending_reg <= 1'b0; // R8
		end
	end

	assign APPLY_NOW = apply_reg;
	assign CHANGE_PENDING = pending_reg;

	// ============================================================
	// Control register.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			enable_reg <= RCRF_CTRL_ENABLE_RST;
		end else if (WR_STB && hit(ADDR, RCRF_REG_CTRL)) begin
			enable_reg <= WR_DATA[RCRF_CTRL_ENABLE];
		end
	end

	// Sticky status flags; write one to clear, a new event wins.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rsvd_seen_reg <= 1'b0;
			sec_ref_reg <= 1'b0;
		end else begin
			if (good_pulse && (cap_reg.options[RCRF_OPT_RSVD_LO] || cap_reg.options[RCRF_OPT_RSVD_HI])) begin
				rsvd_seen_reg <= 1'b1; // R9
			end else if (WR_STB && hit(ADDR, RCRF_REG_STATUS) && WR_DATA[RCRF_ST_RSVD_SEEN]) begin
				rsvd_seen_reg <= 1'b0;
			end
			if (take && state_reg == RCRF_CSUM && csum_ok && is_ours && len_ok && sec_refused) begin
				sec_ref_reg <= 1'b1; // R10
			end else if (WR_STB && hit(ADDR, RCRF_REG_STATUS) && WR_DATA[RCRF_ST_SECURE_REFUSED]) begin
				sec_ref_reg <= 1'b0;
			end
		end
	end

	// Frame counters; any write clears, a count in the same cycle wins.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			good_cnt_reg <= 16'h0000;
			csum_err_cnt_reg <= 16'h0000;
			len_err_cnt_reg <= 16'h0000;
		end else begin
			if (good_pulse) begin
				good_cnt_reg <= 16'(good_cnt_reg + 16'h0001);
			end else if (WR_STB && hit(ADDR, RCRF_REG_GOOD_CNT)) begin
				good_cnt_reg <= 16'h0000;
			end
			if (csum_err_pulse) begin
				csum_err_cnt_reg <= 16'(csum_err_cnt_reg + 16'h0001);
			end else if (WR_STB && hit(ADDR, RCRF_REG_CSUM_ERR_CNT)) begin
				csum_err_cnt_reg <= 16'h0000;
			end
			if (len_err_pulse) begin
				len_err_cnt_reg <= 16'(len_err_cnt_reg + 16'h0001);
			end else if (WR_STB && hit(ADDR, RCRF_REG_LEN_ERR_CNT)) begin
				len_err_cnt_reg <= 16'h0000;
			end
		end
	end

	// ============================================================
	// Read data, present only in the cycle after the read strobe.
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (RD_STB) begin
			unique case (ADDR)
				RCRF_REG_CTRL: rd_data_reg <= {31'h0000_0000, enable_reg};
				RCRF_REG_STATUS: rd_data_reg <= {28'h000_0000, sec_ref_reg, rsvd_seen_reg,
					(state_reg != RCRF_IDLE), pending_reg};
				RCRF_REG_GOOD_CNT: rd_data_reg <= {16'h0000, good_cnt_reg};
				RCRF_REG_CSUM_ERR_CNT: rd_data_reg <= {16'h0000, csum_err_cnt_reg};
				RCRF_REG_LEN_ERR_CNT: rd_data_reg <= {16'h0000, len_err_cnt_reg};
				RCRF_REG_LAST: rd_data_reg <= {req_reg.command, req_reg.frame_id, req_reg.options};
				default: rd_data_reg <= 32'h0000_0000;
			endcase
		end else begin
			rd_data_reg <= 32'h0000_0000;
		end
	end

	assign RD_DATA = rd_data_reg;

endmodule
`default_nettype wire

/* bench/rcrf_framer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Port-level checks on the request parser outputs.
module rcrf_framer_properties (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic RX_VALID,
	input wire logic SECURE_SESSION_UP,
	input wire rcrf_pkg::rcrf_req_s REQ,
	input wire logic REQ_VALID,
	input wire logic REQ_IS_READ,
	input wire logic REQ_NO_ACK,
	input wire logic RSP_REQ,
	input wire logic [7:0] RSP_FRAME_ID,
	input wire logic APPLY_NOW,
	input wire logic CHANGE_PENDING,
	input wire logic FRAME_ERROR
);
	import rcrf_pkg::*;
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (!RST_B);
	// A finished request shows as exactly one cycle of valid.
	sequence s_done;
		REQ_VALID ##1 !REQ_VALID;
	endsequence
	// A failed frame shows as exactly one cycle of error.
	sequence s_err;
		FRAME_ERROR ##1 !FRAME_ERROR;
	endsequence
	property p_rsp_only_with_id;
		RSP_REQ |-> REQ_VALID && RSP_FRAME_ID != 8'h00;
	endproperty
	property p_rsp_echo;
		REQ_VALID && REQ.frame_id != 8'h00 |-> RSP_REQ && RSP_FRAME_ID == REQ.frame_id;
	endproperty
	property p_read_flag;
		REQ_VALID && REQ_IS_READ |-> APPLY_NOW || CHANGE_PENDING == $past(CHANGE_PENDING);
	endproperty
	property p_no_ack;
		REQ_VALID |-> REQ_NO_ACK == REQ.options[RCRF_OPT_NO_ACK];
	endproperty
	property p_secure;
		REQ_VALID && REQ.options[RCRF_OPT_SECURE] |-> $past(SECURE_SESSION_UP);
	endproperty
	property p_apply_bit;
		REQ_VALID && REQ.options[RCRF_OPT_APPLY] |-> APPLY_NOW && !CHANGE_PENDING;
	endproperty
	property p_queue;
		REQ_VALID && !REQ.options[RCRF_OPT_APPLY] && REQ.value_len != 16'h0000
			&& REQ.command != RCRF_CMD_APPLY_PENDING |-> CHANGE_PENDING;
	endproperty
	property p_end_of_frame;
		REQ_VALID |-> $past(RX_VALID) ##0 s_done;
	endproperty
	property p_error_pulse;
		FRAME_ERROR |-> !REQ_VALID && $past(RX_VALID) ##0 s_err;
	endproperty
	property p_req_holds;
		!REQ_VALID |-> $stable(REQ);
	endproperty
	a_rsp_only_with_id: assert property (p_rsp_only_with_id) else $error("response without id");
	a_rsp_echo: assert property (p_rsp_echo) else $error("response id not echoed");
	a_read_flag: assert property (p_read_flag) else $error("read queued a change");
	a_no_ack: assert property (p_no_ack) else $error("no ack flag wrong");
	a_secure: assert property (p_secure) else $error("secure request without session");
	a_apply_bit: assert property (p_apply_bit) else $error("apply bit not honoured");
	a_queue: assert property (p_queue) else $error("write not queued");
	a_end_of_frame: assert property (p_end_of_frame) else $error("valid not after checksum");
	a_error_pulse: assert property (p_error_pulse) else $error("error pulse wrong");
	a_req_holds: assert property (p_req_holds) else $error("request changed without valid");
endmodule
bind rcrf_framer rcrf_framer_properties i_props (.CLOCK(CLOCK), .RST_B(RST_B), .RX_VALID(RX_VALID),
	.SECURE_SESSION_UP(SECURE_SESSION_UP), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_IS_READ(REQ_IS_READ),
	.REQ_NO_ACK(REQ_NO_ACK), .RSP_REQ(RSP_REQ), .RSP_FRAME_ID(RSP_FRAME_ID), .APPLY_NOW(APPLY_NOW),
	.CHANGE_PENDING(CHANGE_PENDING), .FRAME_ERROR(FRAME_ERROR));
`default_nettype wire

/* bench/rcrf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Host model: serialises request frames onto the byte stream.
module rcrf_host_model (
	input wire logic CLOCK,
	output logic [7:0] RX_DATA,
	output logic RX_VALID
);
	import rcrf_pkg::*;
	logic [7:0] fb [$];
	// Idle stream at time zero.
	initial begin
		RX_DATA = 8'h00;
		RX_VALID = 1'b0;
	end
	// Sends one request; a nonzero bad value spoils the checksum on purpose.
	task automatic send(input logic [7:0] id, input logic [7:0] opt, input logic [15:0] cmd,
		input int nval, input logic [7:0] bad);
		logic [7:0] sum;
		logic [15:0] len;
		fb = {RCRF_TYPE_REMOTE_CFG, id};
		// Odd identifiers address by short address, even ones by the long address.
		if (id[0]) begin
			repeat (8) fb.push_back(8'hff);
			fb.push_back(8'h12);
			fb.push_back(8'h34);
		end else begin
			for (int i = 0; i < 8; i++) fb.push_back(8'h10 + 8'(i));
			fb.push_back(8'hff);
			fb.push_back(8'hfe);
		end
		fb.push_back(opt);
		fb.push_back(cmd[15:8]);
		fb.push_back(cmd[7:0]);
		for (int i = 0; i < nval; i++) fb.push_back(8'h30 + 8'(i));
		sum = 8'h00;
		foreach (fb[i]) sum += fb[i];
		len = 16'(fb.size());
		fb.push_back(8'hff - sum + bad);
		fb.push_front(len[7:0]);
		fb.push_front(len[15:8]);
		fb.push_front(RCRF_START_MARK);
		foreach (fb[i]) begin
			@(posedge CLOCK);
			RX_DATA <= fb[i];
			RX_VALID <= 1'b1;
		end
		@(posedge CLOCK);
		// A released line never keeps showing the last byte.
		RX_DATA <= ~RX_DATA;
		RX_VALID <= 1'b0;
	endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Self-checking bench for the request framer.
module tb_top;
	import rcrf_pkg::*;
	typedef struct {
		logic [7:0] id;
		logic [7:0] opt;
		logic [15:0] cmd;
		int nval;
		logic [3:0] exp; // Read, response, apply, pending.
	} rcrf_row_s;
	rcrf_row_s rows [5] = '{'{8'hfa, 8'h00, 16'h5450, 0, 4'b1100}, '{8'h68, 8'h00, 16'h4944, 2, 4'b0101},
		'{8'h27, 8'h02, 16'h4e49, 6, 4'b0110}, '{8'h00, 8'h01, 16'h4944, 1, 4'b0001},
		'{8'h05, 8'h00, RCRF_CMD_APPLY_PENDING, 0, 4'b1110}};
	logic CLOCK, RST_B, RX_VALID, SEC, REQ_VALID, REQ_IS_READ, REQ_NO_ACK, REQ_SECURE, RSP_REQ;
	logic APPLY_NOW, CHANGE_PENDING, FRAME_ERROR, WR_STB, RD_STB, hit;
	logic [7:0] RX_DATA, RSP_FRAME_ID, VAL_DATA, ADDR;
	logic [5:0] VAL_IDX;
	logic [31:0] WR_DATA, RD_DATA, d;
	rcrf_req_s REQ;
	int miscompares = 0;
	int n_tests = 0;
	rcrf_host_model i_rcrf_host_model (.CLOCK(CLOCK), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID));
	rcrf_framer i_rcrf_framer (.CLOCK(CLOCK), .RST_B(RST_B), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
		.SECURE_SESSION_UP(SEC), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_IS_READ(REQ_IS_READ),
		.REQ_NO_ACK(REQ_NO_ACK), .REQ_SECURE(REQ_SECURE), .RSP_REQ(RSP_REQ), .RSP_FRAME_ID(RSP_FRAME_ID),
		.APPLY_NOW(APPLY_NOW), .CHANGE_PENDING(CHANGE_PENDING), .FRAME_ERROR(FRAME_ERROR),
		.VAL_IDX(VAL_IDX), .VAL_DATA(VAL_DATA), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_STB(WR_STB),
		.RD_STB(RD_STB), .RD_DATA(RD_DATA));
	// Free-running system clock.
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Compares one observed value with its expectation.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Waits a bounded time for a frame outcome; a required one that never comes ends the run.
	task automatic wait_ev(input logic must);
		hit = 1'b0;
		for (int i = 0; i < 40 && !hit; i++) begin
			@(negedge CLOCK);
			hit = (REQ_VALID | FRAME_ERROR) === 1'b1;
		end
		if (must && !hit) begin
			chk("frame outcome", 1, 0);
			end_sim();
		end
	endtask
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLOCK);
		ADDR <= a;
		WR_DATA <= v;
		WR_STB <= 1'b1;
		@(posedge CLOCK);
		WR_STB <= 1'b0;
	endtask
	// One-cycle register read; data is taken in the following cycle.
	task automatic rd(input logic [7:0] a);
		@(posedge CLOCK);
		ADDR <= a;
		RD_STB <= 1'b1;
		@(posedge CLOCK);
		RD_STB <= 1'b0;
		@(negedge CLOCK);
		d = RD_DATA;
	endtask
	// Main sequence: control reset check, table rows, then hand-written cases.
	initial begin
		RST_B = 1'b0;
		SEC = 1'b0;
		VAL_IDX = 6'h00;
		ADDR = 8'h00;
		WR_DATA = 32'h0;
		WR_STB = 1'b0;
		RD_STB = 1'b0;
		repeat (4) @(posedge CLOCK);
		RST_B <= 1'b1;
		rd(RCRF_REG_CTRL);
		chk("ctrl reset", 32'h1, d);
		foreach (rows[i]) begin
			i_rcrf_host_model.send(rows[i].id, rows[i].opt, rows[i].cmd, rows[i].nval, 8'h00);
			wait_ev(1'b1);
			chk("req valid", 1, REQ_VALID);
			chk("command", rows[i].cmd, REQ.command);
			chk("options", rows[i].opt, REQ.options);
			chk("value len", rows[i].nval, REQ.value_len);
			chk("flags", rows[i].exp, {REQ_IS_READ, RSP_REQ, APPLY_NOW, CHANGE_PENDING});
			chk("echo id", rows[i].id, RSP_FRAME_ID);
			chk("no ack", rows[i].opt[0], REQ_NO_ACK);
			chk("dest16", rows[i].id[0] ? 32'h0000_1234 : 32'h0000_fffe, REQ.dest16);
			chk("dest64 low", rows[i].id[0] ? 32'hffff_ffff : 32'h1415_1617, REQ.dest64[31:0]);
		end
		i_rcrf_host_model.send(8'h11, 8'h00, 16'h4944, 2, 8'h01);
		wait_ev(1'b1);
		chk("error", 2'b01, {REQ_VALID, FRAME_ERROR});
		rd(RCRF_REG_CSUM_ERR_CNT);
		chk("csum count", 32'h1, d);
		i_rcrf_host_model.send(8'h21, 8'h10, 16'h4944, 1, 8'h00);
		wait_ev(1'b0);
		chk("secure refused", 0, hit);
		rd(RCRF_REG_STATUS);
		chk("secure flag", 1, d[RCRF_ST_SECURE_REFUSED]);
		chk("reserved flag", 0, d[RCRF_ST_RSVD_SEEN]);
		@(posedge CLOCK);
		SEC <= 1'b1;
		i_rcrf_host_model.send(8'h22, 8'h10, 16'h4944, 3, 8'h00);
		wait_ev(1'b1);
		chk("secure", 2'b11, {REQ_SECURE, CHANGE_PENDING});
		rd(RCRF_REG_LAST);
		chk("last request", 32'h4944_2210, d);
		@(posedge CLOCK);
		VAL_IDX <= 6'h02;
		@(posedge CLOCK);
		@(negedge CLOCK);
		chk("value byte", 8'h32, VAL_DATA);
		wr(RCRF_REG_CTRL, 32'h3);
		@(negedge CLOCK);
		chk("ctrl apply", 2'b10, {APPLY_NOW, CHANGE_PENDING});
		wr(RCRF_REG_CTRL, 32'h0);
		i_rcrf_host_model.send(8'h23, 8'h00, 16'h5450, 0, 8'h00);
		wait_ev(1'b0);
		chk("disabled", 0, hit);
		wr(RCRF_REG_CTRL, 32'h1);
		rd(RCRF_REG_GOOD_CNT);
		chk("good count", 32'h6, d);
		rd(8'h40);
		chk("unmapped", 32'h0, d);
		@(posedge CLOCK);
		RST_B <= 1'b0;
		@(negedge CLOCK);
		chk("reset outputs", 10'h200, {REQ_IS_READ, RSP_FRAME_ID, CHANGE_PENDING});
		@(posedge CLOCK);
		RST_B <= 1'b1;
		rd(RCRF_REG_CTRL);
		chk("ctrl after reset", 32'h1, d);
		end_sim();
	end
endmodule
`default_nettype wire
